//--- design/cpu_mode_pkg.sv
package cpu_mode_pkg;
    localparam logic [11:0] CPU_MODE_STACK_BANK_ADDR = 12'h0f84;
    localparam logic [3:0] CPU_MODE_STACK_BANK_RESET = 4'h8;
    localparam int MODE_BIT = 3;
    localparam int BANK_HI_BIT = 1;
    localparam int BANK_LO_BIT = 0;
    localparam int RSVD_BIT = 2;
    localparam logic [2:0] FRAME_BYTES_LEGACY = 3'h2;
    localparam logic [2:0] FRAME_BYTES_EXTENDED = 3'h3;
    localparam logic [2:0] CYCLES_CALL_LONG_LEGACY = 3'h3;
    localparam logic [2:0] CYCLES_CALL_FIXED_LEGACY = 3'h2;
    localparam logic [2:0] CYCLES_EXTRA_EXTENDED = 3'h1;
    typedef enum logic [2:0] {
        OP_OTHER,
        OP_JUMP_EXTENDED,
        OP_SUBROUTINE_JUMP_EXTENDED,
        OP_SUBROUTINE_JUMP_LONG,
        OP_SUBROUTINE_JUMP_FIXED_AREA
    } op_class_type;
    typedef enum logic {
        EXTENDED_PROGRAM_MODE,
        LEGACY_COMPAT_MODE
    } cpu_mode_type;
endpackage

//--- design/call_timing.sv
module call_timing
    import cpu_mode_pkg::*;
(
    input wire logic legacy,
    input wire op_class_type op,
    output logic [2:0] frame_bytes,
    output logic [2:0] call_cycles,
    output logic is_call,
    output logic op_legal
);
    always_comb begin
        is_call = (op == OP_SUBROUTINE_JUMP_LONG) || (op == OP_SUBROUTINE_JUMP_FIXED_AREA)
            || (op == OP_SUBROUTINE_JUMP_EXTENDED);
        frame_bytes = legacy ? FRAME_BYTES_LEGACY : FRAME_BYTES_EXTENDED; // [RULE3]
        op_legal = 1'b1;
        call_cycles = 3'h0;
        unique case (op)
            OP_SUBROUTINE_JUMP_LONG: begin
                call_cycles = legacy ? CYCLES_CALL_LONG_LEGACY
                    : CYCLES_CALL_LONG_LEGACY + CYCLES_EXTRA_EXTENDED; // [RULE4]
            end
            OP_SUBROUTINE_JUMP_FIXED_AREA: begin
                call_cycles = legacy ? CYCLES_CALL_FIXED_LEGACY
                    : CYCLES_CALL_FIXED_LEGACY + CYCLES_EXTRA_EXTENDED; // [RULE4]
            end
            OP_JUMP_EXTENDED, OP_SUBROUTINE_JUMP_EXTENDED: begin
                op_legal = !legacy; // [RULE5]
            end
            OP_OTHER: begin
                op_legal = 1'b1;
            end
            default: begin
                op_legal = 1'b0;
            end
        endcase
    end
endmodule // call_timing

//--- design/cpu_mode_stack_bank_select.sv
// Behaviour
// [RULE1] Register bit 3 selects mode: 0 extended, 1 legacy.
// [RULE2] Reset loads bit 3 high, so the CPU starts in legacy mode.
// [RULE3] Calls push 2 bytes in legacy mode, 3 bytes in extended mode.
// [RULE4] Long call 3 cycles, fixed-area call 2; extended adds one.
// [RULE5] Extended jump and extended call are accepted only in extended mode.
// [RULE6] The register is written by a 4-bit memory operation.
// [RULE7] Software initialises the register to 100x or 000x at program start.
// [RULE8] Bits 1-0 pick stack bank 0 or 1; other values, bit 2 set prohibited.
module cpu_mode_stack_bank_select
    import cpu_mode_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [11:0] mem_addr,
    input wire logic mem_wr,
    input wire logic mem_rd,
    input wire logic [3:0] mem_wdata,
    output logic [3:0] mem_rdata,
    output logic mem_hit,
    input wire op_class_type op_class,
    input wire logic op_valid,
    output logic legacy_compat_mode,
    output logic stack_bank,
    output logic [2:0] push_bytes_reg,
    output logic [2:0] call_cycles_reg,
    output logic op_accept_reg,
    output logic op_illegal_reg,
    output logic setting_error_reg
);
    ////////////////////////////////////////////////////////////////////////
    // Register
    logic [3:0] stack_bank_select_reg;
    logic sel;
    logic [2:0] frame_bytes;
    logic [2:0] call_cycles;
    logic is_call;
    logic op_legal;

    assign sel = (mem_addr == CPU_MODE_STACK_BANK_ADDR);
    assign mem_hit = sel && (mem_wr || mem_rd);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stack_bank_select_reg <= CPU_MODE_STACK_BANK_RESET; // [RULE2]
        end else if (sel && mem_wr) begin
            stack_bank_select_reg <= mem_wdata; // [RULE6]
        end
    end

    always_comb begin
        mem_rdata = (sel && mem_rd) ? stack_bank_select_reg : 4'h0;
    end

    assign legacy_compat_mode = stack_bank_select_reg[MODE_BIT]; // [RULE1]
    assign stack_bank = stack_bank_select_reg[BANK_LO_BIT]; // [RULE8]

    // Flags a prohibited setting written by software
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            setting_error_reg <= 1'b0;
        end else if (sel && mem_wr) begin
            setting_error_reg <= mem_wdata[RSVD_BIT] || mem_wdata[BANK_HI_BIT]; // [RULE8]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Decode
    call_timing i_call_timing (
        .legacy(legacy_compat_mode),
        .op(op_class),
        .frame_bytes(frame_bytes),
        .call_cycles(call_cycles),
        .is_call(is_call),
        .op_legal(op_legal)
    );

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            op_accept_reg <= 1'b0;
            op_illegal_reg <= 1'b0;
            push_bytes_reg <= 3'h0;
            call_cycles_reg <= 3'h0;
        end else begin
            op_accept_reg <= op_valid && op_legal; // [RULE5]
            op_illegal_reg <= op_valid && !op_legal; // [RULE5]
            push_bytes_reg <= (op_valid && op_legal && is_call) ? frame_bytes : 3'h0; // [RULE3]
            call_cycles_reg <= op_valid ? call_cycles : 3'h0; // [RULE4]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    sequence s_reg_write;
        sel && mem_wr;
    endsequence

    sequence s_to_extended;
        sel && mem_wr && !mem_wdata[MODE_BIT];
    endsequence

    sequence s_quiet_bus;
        !(sel && mem_wr);
    endsequence

    sequence s_long_call;
        op_valid && op_class == OP_SUBROUTINE_JUMP_LONG;
    endsequence

    property p_mode_bit;
        @(posedge clk) disable iff (!resetn)
        s_reg_write |=> (legacy_compat_mode == $past(mem_wdata[MODE_BIT]));
    endproperty
    a_mode_bit: assert property (p_mode_bit) else $error("mode not from bit 3"); // [RULE1]

    property p_write;
        @(posedge clk) disable iff (!resetn)
        (sel && mem_wr) |=> (stack_bank_select_reg == $past(mem_wdata));
    endproperty
    a_write: assert property (p_write) else $error("write not stored"); // [RULE6]

    property p_reset_legacy;
        @(posedge clk) $rose(resetn) |-> legacy_compat_mode;
    endproperty
    a_reset_legacy: assert property (p_reset_legacy) else $error("reset not legacy"); // [RULE2]

    sequence s_call_ext;
        op_valid && is_call && !legacy_compat_mode;
    endsequence
    property p_push_ext;
        @(posedge clk) disable iff (!resetn)
        s_call_ext |=> (push_bytes_reg == 3'h3);
    endproperty
    a_push_ext: assert property (p_push_ext) else $error("extended push not 3"); // [RULE3]

    property p_push_leg;
        @(posedge clk) disable iff (!resetn)
        (op_valid && legacy_compat_mode && (op_class == OP_SUBROUTINE_JUMP_LONG
            || op_class == OP_SUBROUTINE_JUMP_FIXED_AREA)) |=> (push_bytes_reg == 3'h2);
    endproperty
    a_push_leg: assert property (p_push_leg) else $error("legacy push not 2"); // [RULE3]

    property p_long_cycles;
        @(posedge clk) disable iff (!resetn)
        (op_valid && op_class == OP_SUBROUTINE_JUMP_LONG)
            |=> (call_cycles_reg == ($past(legacy_compat_mode) ? 3'h3 : 3'h4));
    endproperty
    a_long_cycles: assert property (p_long_cycles) else $error("long call cycles"); // [RULE4]

    property p_fixed_cycles;
        @(posedge clk) disable iff (!resetn)
        (op_valid && op_class == OP_SUBROUTINE_JUMP_FIXED_AREA)
            |=> (call_cycles_reg == ($past(legacy_compat_mode) ? 3'h2 : 3'h3));
    endproperty
    a_fixed_cycles: assert property (p_fixed_cycles) else $error("fixed call cycles"); // [RULE4]

    property p_ext_refused;
        @(posedge clk) disable iff (!resetn)
        (op_valid && legacy_compat_mode
            && (op_class == OP_JUMP_EXTENDED || op_class == OP_SUBROUTINE_JUMP_EXTENDED))
            |=> (op_illegal_reg && !op_accept_reg);
    endproperty
    a_ext_refused: assert property (p_ext_refused) else $error("extended op taken"); // [RULE5]

    property p_bank;
        @(posedge clk) disable iff (!resetn)
        (sel && mem_wr && mem_wdata[RSVD_BIT:BANK_LO_BIT] == 3'b001)
            |=> stack_bank && !setting_error_reg;
    endproperty
    a_bank: assert property (p_bank) else $error("bank 1 not selected"); // [RULE8]

    property p_bank0;
        @(posedge clk) disable iff (!resetn)
        (sel && mem_wr && mem_wdata[BANK_LO_BIT] == 1'b0) |=> !stack_bank;
    endproperty
    a_bank0: assert property (p_bank0) else $error("bank 0 not selected"); // [RULE8]

    property p_setting_error;
        @(posedge clk) disable iff (!resetn)
        (sel && mem_wr && (mem_wdata[RSVD_BIT] || mem_wdata[BANK_HI_BIT])) |=> setting_error_reg;
    endproperty
    a_setting_error: assert property (p_setting_error) else $error("bad setting not flagged"); // [RULE8]

    property p_hold;
        @(posedge clk) disable iff (!resetn)
        s_quiet_bus |=> $stable(stack_bank_select_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("register changed without write"); // [RULE6]

    property p_ext_accepted;
        @(posedge clk) disable iff (!resetn)
        (op_valid && !legacy_compat_mode
            && (op_class == OP_JUMP_EXTENDED || op_class == OP_SUBROUTINE_JUMP_EXTENDED))
            |=> (op_accept_reg && !op_illegal_reg);
    endproperty
    a_ext_accepted: assert property (p_ext_accepted) else $error("extended op refused"); // [RULE5]

    property p_no_push;
        @(posedge clk) disable iff (!resetn)
        (op_valid && (op_class == OP_OTHER || op_class == OP_JUMP_EXTENDED))
            |=> (push_bytes_reg == 3'h0);
    endproperty
    a_no_push: assert property (p_no_push) else $error("push without call"); // [RULE3]

    property p_no_cycles;
        @(posedge clk) disable iff (!resetn)
        (op_valid && (op_class == OP_OTHER || op_class == OP_JUMP_EXTENDED
            || op_class == OP_SUBROUTINE_JUMP_EXTENDED)) |=> (call_cycles_reg == 3'h0);
    endproperty
    a_no_cycles: assert property (p_no_cycles) else $error("cycles for other op"); // [RULE4]

    property p_idle;
        @(posedge clk) disable iff (!resetn)
        !op_valid |=> (!op_accept_reg && !op_illegal_reg && push_bytes_reg == 3'h0);
    endproperty
    a_idle: assert property (p_idle) else $error("result without op"); // [RULE5]

    property p_reset_outputs;
        @(posedge clk)
        $rose(resetn) |-> (!op_accept_reg && !op_illegal_reg && push_bytes_reg == 3'h0
            && stack_bank_select_reg == CPU_MODE_STACK_BANK_RESET);
    endproperty
    a_reset_outputs: assert property (p_reset_outputs) else $error("reset state wrong"); // [RULE2]

    property p_switch_then_call;
        @(posedge clk) disable iff (!resetn)
        s_to_extended ##1 s_quiet_bus ##1 s_long_call
            |=> (call_cycles_reg == 3'h4 && push_bytes_reg == 3'h3);
    endproperty
    a_switch_then_call: assert property (p_switch_then_call) else $error("switch not seen"); // [RULE4]
endmodule // cpu_mode_stack_bank_select

//--- bench/tb_cpu_mode_stack_bank_select.sv
module tb_cpu_mode_stack_bank_select
    import cpu_mode_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [11:0] mem_addr = 12'h000;
    logic mem_wr = 1'b0;
    logic mem_rd = 1'b0;
    logic [3:0] mem_wdata = 4'h0;
    logic [3:0] mem_rdata;
    logic mem_hit;
    op_class_type op_class = OP_OTHER;
    logic op_valid = 1'b0;
    logic legacy_compat_mode;
    logic stack_bank;
    logic [2:0] push_bytes_reg;
    logic [2:0] call_cycles_reg;
    logic op_accept_reg;
    logic op_illegal_reg;
    logic setting_error_reg;
    int err_total = 0;
    int comparisons = 0;
    cpu_mode_stack_bank_select i_cpu_mode_stack_bank_select (.clk(clk), .resetn(resetn),
        .mem_addr(mem_addr), .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .mem_hit(mem_hit), .op_class(op_class), .op_valid(op_valid),
        .legacy_compat_mode(legacy_compat_mode), .stack_bank(stack_bank),
        .push_bytes_reg(push_bytes_reg), .call_cycles_reg(call_cycles_reg),
        .op_accept_reg(op_accept_reg), .op_illegal_reg(op_illegal_reg),
        .setting_error_reg(setting_error_reg));
    always #20 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////
    task chk(input logic [3:0] seen, input logic [3:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task wrap_up;
        $display("comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task wr(input logic [11:0] a, input logic [3:0] d);
        @(posedge clk);
        mem_addr <= a;
        mem_wdata <= d;
        mem_wr <= 1'b1;
        #1;
        chk(mem_hit, a == CPU_MODE_STACK_BANK_ADDR);
        @(posedge clk);
        mem_wr <= 1'b0;
        #1;
    endtask
    task rd(input logic [11:0] a, input logic [3:0] exp);
        @(posedge clk);
        mem_addr <= a;
        mem_rd <= 1'b1;
        #1;
        chk(mem_rdata, exp);
        chk(mem_hit, a == CPU_MODE_STACK_BANK_ADDR);
        @(posedge clk);
        mem_rd <= 1'b0;
    endtask
    task op(input op_class_type c, input logic ok, input logic [2:0] cyc, input logic [2:0] byt);
        @(posedge clk);
        op_class <= c;
        op_valid <= 1'b1;
        @(posedge clk);
        op_valid <= 1'b0;
        #1;
        chk(op_accept_reg, ok);
        chk(op_illegal_reg, !ok);
        chk(call_cycles_reg, cyc);
        chk(push_bytes_reg, byt);
    endtask
    task ops(input logic leg);
        logic [2:0] fb;
        logic [2:0] ex;
        fb = leg ? FRAME_BYTES_LEGACY : FRAME_BYTES_EXTENDED;
        ex = leg ? 3'h0 : CYCLES_EXTRA_EXTENDED;
        chk(legacy_compat_mode, leg);
        op(OP_SUBROUTINE_JUMP_LONG, 1'b1, CYCLES_CALL_LONG_LEGACY + ex, fb);
        op(OP_SUBROUTINE_JUMP_FIXED_AREA, 1'b1, CYCLES_CALL_FIXED_LEGACY + ex, fb);
        op(OP_JUMP_EXTENDED, !leg, 3'h0, 3'h0);
        op(OP_SUBROUTINE_JUMP_EXTENDED, !leg, 3'h0, leg ? 3'h0 : fb);
        op(OP_OTHER, 1'b1, 3'h0, 3'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        rd(CPU_MODE_STACK_BANK_ADDR, 4'h8);
        chk({setting_error_reg, stack_bank}, 4'h0);
        ops(1'b1);
        wr(CPU_MODE_STACK_BANK_ADDR, 4'h1);
        rd(CPU_MODE_STACK_BANK_ADDR, 4'h1);
        chk({setting_error_reg, stack_bank}, 4'h1);
        ops(1'b0);
        wr(CPU_MODE_STACK_BANK_ADDR, 4'h4);
        chk(setting_error_reg, 1'b1);
        wr(CPU_MODE_STACK_BANK_ADDR, 4'h2);
        chk(setting_error_reg, 1'b1);
        wr(CPU_MODE_STACK_BANK_ADDR, 4'h9);
        chk({setting_error_reg, legacy_compat_mode, stack_bank}, 4'h3);
        wr(12'h0f85, 4'h0);
        rd(CPU_MODE_STACK_BANK_ADDR, 4'h9);
        rd(12'h0f85, 4'h0);
        wr(CPU_MODE_STACK_BANK_ADDR, 4'h0);
        op(OP_SUBROUTINE_JUMP_LONG, 1'b1, 3'h4, 3'h3);
        @(posedge clk);
        resetn <= 1'b0;
        @(posedge clk);
        #1;
        chk({legacy_compat_mode, stack_bank}, 4'h2);
        chk(push_bytes_reg, 3'h0);
        @(posedge clk);
        resetn <= 1'b1;
        rd(CPU_MODE_STACK_BANK_ADDR, 4'h8);
        wrap_up;
    end
    initial begin
        #(2000 * 40);
        err_total++;
        wrap_up;
    end
endmodule // tb_cpu_mode_stack_bank_select
